// ### rtl/cmh_msg_handler.sv
// Message object store, acceptance filter, transmit selection and
// interrupt identification for a two-node CAN controller.
// Assumes the bitstream processors share hclk; AHB-Lite single word access.
`timescale 1ns/1ps
`include "cmh_regs.svh"

module cmh_msg_handler (
	input  logic                              hclk,
	input  logic                              hresetn,
	input  logic                              hsel,
	input  logic [31:0]                       haddr,
	input  logic [1:0]                        htrans,
	input  logic                              hwrite,
	input  logic [2:0]                        hsize,
	input  logic [31:0]                       hwdata,
	input  logic                              hready,
	output logic                              hreadyout,
	output logic                              hresp,
	output logic [31:0]                       hrdata,
	input  logic [1:0]                        rx_valid,
	output logic [1:0]                        rx_ready,
	input  logic [1:0]                        rx_remote,
	input  logic [1:0]                        rx_xtd,
	input  cmh_pkg::cmh_id_t [1:0]            rx_id,
	input  cmh_pkg::cmh_dlc_t [1:0]           rx_dlc,
	input  cmh_pkg::cmh_data_t [1:0]          rx_data,
	input  logic [1:0]                        node_bus_idle,
	output logic [1:0]                        tx_avail,
	input  logic [1:0]                        tx_take,
	input  logic [1:0]                        tx_done,
	input  logic [1:0]                        tx_fail,
	output logic [1:0]                        tx_remote,
	output logic [1:0]                        tx_xtd,
	output cmh_pkg::cmh_id_t [1:0]            tx_id,
	output cmh_pkg::cmh_dlc_t [1:0]           tx_dlc,
	output cmh_pkg::cmh_data_t [1:0]          tx_data,
	input  logic [1:0][3:0]                   node_irq_src
);
	import cmh_pkg::*;

	// ************************************************************
	// Helpers
	// ************************************************************
	// Lowest set bit: {found, index}
	function automatic logic [5:0] lowest32(input logic [31:0] v);
		logic [5:0] r;
		r = 6'h00;
		for (int k = 31; k >= 0; k--) begin
			if (v[k]) begin
				r = {1'b1, 5'(k)};
			end
		end
		return r;
	endfunction : lowest32

	// Set wins over clear, from either side
	function automatic logic flag_next(input logic cur, input logic wr, input logic [1:0] code,
					   input logic hset, input logic hclr);
		logic sw_set;
		logic sw_clr;
		sw_set = wr && (code == `CMH_FLAG_SET);
		sw_clr = wr && (code == `CMH_FLAG_CLR);
		return (cur && !hclr && !sw_clr) || hset || sw_set;
	endfunction : flag_next

	function automatic logic [1:0] enc(input logic f);
		return f ? `CMH_FLAG_SET : `CMH_FLAG_CLR;
	endfunction : enc

	// ************************************************************
	// AHB-Lite slave
	// ************************************************************
	cmh_bus_e                 bus_q;
	cmh_bus_e                 bus_d;
	logic                     wr_q;
	logic [`CMH_ADDR_W-1:0]   addr_q;
	logic [31:0]              rd_word;
	logic [31:0]              hrdata_q;
	logic                     ahb_take;

	assign ahb_take  = hsel && hready && htrans[1];
	assign hreadyout = (bus_q != CMH_BUS_RDWAIT);
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_q;

	always_comb begin
		case (bus_q)
			CMH_BUS_IDLE, CMH_BUS_RDOUT: begin
				bus_d = (ahb_take && !hwrite) ? CMH_BUS_RDWAIT : CMH_BUS_IDLE;
			end
			CMH_BUS_RDWAIT: begin
				bus_d = CMH_BUS_RDOUT;
			end
			default: begin
				bus_d = CMH_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_q    <= CMH_BUS_IDLE;
			wr_q     <= 1'b0;
			addr_q   <= '0;
			hrdata_q <= 32'h0000_0000;
		end else begin
			bus_q <= bus_d;
			wr_q  <= ahb_take && hwrite;
			if (ahb_take) begin
				addr_q <= haddr[`CMH_ADDR_W-1:0];
			end
			if (bus_q == CMH_BUS_RDWAIT) begin
				hrdata_q <= rd_word;
			end
		end
	end

	logic                     obj_wr;
	logic                     glb_wr;
	logic [4:0]               a_obj;
	logic [2:0]               a_word;
	logic [3:0]               a_gidx;

	assign a_obj  = addr_q[`CMH_OBJ_MSB:`CMH_OBJ_LSB];
	assign a_word = addr_q[`CMH_WORD_MSB:`CMH_WORD_LSB];
	assign a_gidx = addr_q[`CMH_GIDX_MSB:`CMH_WORD_LSB];
	assign obj_wr = wr_q && !addr_q[`CMH_GLB_BIT];
	assign glb_wr = wr_q && addr_q[`CMH_GLB_BIT];

	// ************************************************************
	// Receive path and acceptance filter
	// ************************************************************
	logic [1:0]               rx_acc;
	logic                     rx_go;
	logic                     r_node;
	logic                     r_remote;
	logic                     r_xtd;
	cmh_id_t                  r_id;
	cmh_dlc_t                 r_dlc;
	cmh_data_t                r_data;
	logic [31:0]              cand;
	logic [5:0]               hit;
	logic                     rx_store;

	// One frame per cycle, node 0 first
	assign rx_ready = {!rx_valid[0], 1'b1};
	assign rx_acc   = rx_valid & rx_ready;
	assign rx_go    = |rx_acc;
	assign r_node   = rx_acc[1];
	assign r_remote = rx_remote[r_node];
	assign r_xtd    = rx_xtd[r_node];
	assign r_id     = rx_id[r_node];
	assign r_dlc    = rx_dlc[r_node];
	assign r_data   = rx_data[r_node];
	assign hit      = lowest32(cand);
	assign rx_store = rx_go && hit[5] && !r_remote;

	// ************************************************************
	// Global registers and per-node state
	// ************************************************************
	logic                     gw_q;
	logic [1:0][31:0]         omask_q;
	logic [1:0][3:0]          nmask_q;
	logic [1:0]               fcen_q;
	cmh_cnt_t [1:0]           fc_q;
	logic [1:0]               busy_q;
	logic [1:0][4:0]          tx_idx_q;
	logic [1:0][31:0]         pend;
	logic [1:0][5:0]          pick;
	logic [1:0]               take_ok;
	logic [1:0]               done_ok;
	logic [1:0]               done_v;
	logic [1:0][31:0]         ident_w;
	logic [1:0][31:0]         irq_obj;
	logic [1:0][31:0]         fcr_w;

	// Per-object views for selection and read-back
	logic [31:0]              valid_w;
	logic [31:0]              ctrl_word [`CMH_NUM_OBJ];
	cmh_id_t                  obj_id    [`CMH_NUM_OBJ];
	cmh_id_t                  obj_mask  [`CMH_NUM_OBJ];
	logic [7:0]               obj_cfg   [`CMH_NUM_OBJ];
	cmh_data_t                obj_data  [`CMH_NUM_OBJ];
	cmh_cnt_t                 obj_cfc   [`CMH_NUM_OBJ];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gw_q <= 1'b0;
		end else if (glb_wr && a_gidx == `CMH_G_GWCTRL) begin
			gw_q <= hwdata[`CMH_GW_EN];
		end
	end

	for (genvar n = 0; n < `CMH_NUM_NODE; n++) begin : g_node
		logic       w_omask;
		logic       w_nmask;
		logic       w_fcr;
		logic       fc_inc;
		logic [5:0] msg_hit;
		logic [5:0] node_hit;

		assign w_omask  = glb_wr && (a_gidx == (n == 0 ? `CMH_G_OMASK0 : `CMH_G_OMASK1));
		assign w_nmask  = glb_wr && (a_gidx == (n == 0 ? `CMH_G_NMASK0 : `CMH_G_NMASK1));
		assign w_fcr    = glb_wr && (a_gidx == (n == 0 ? `CMH_G_FCR0 : `CMH_G_FCR1));
		assign pick[n]  = lowest32(pend[n]);
		assign tx_avail[n] = pick[n][5] && node_bus_idle[n] && !busy_q[n];
		assign take_ok[n]  = tx_take[n] && tx_avail[n];
		assign done_ok[n]  = tx_done[n] && busy_q[n];
		assign done_v[n]   = done_ok[n] && valid_w[tx_idx_q[n]];
		assign fc_inc = fcen_q[n] && ((rx_store && r_node == n) || done_v[n]);
		assign fcr_w[n] = {fc_q[n], 15'h0000, fcen_q[n]};

		// Identifier: message sources first, then node sources
		assign msg_hit  = lowest32(irq_obj[n] & omask_q[n]);
		assign node_hit = lowest32({28'h0000000, node_irq_src[n] & nmask_q[n]});
		assign ident_w[n] = msg_hit[5]  ? {26'h0, `CMH_IRQ_MSG_BASE + {1'b0, msg_hit[4:0]}} :
				    node_hit[5] ? {26'h0, `CMH_IRQ_NODE_BASE + node_hit[5:0] - 6'h20} :
				    {26'h0, `CMH_IRQ_NONE};

		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				omask_q[n]  <= 32'h0000_0000;
				nmask_q[n]  <= 4'h0;
				fcen_q[n]   <= 1'b0;
				fc_q[n]     <= 16'h0000;
				busy_q[n]   <= 1'b0;
				tx_idx_q[n] <= 5'h00;
				tx_remote[n] <= 1'b0;
				tx_xtd[n]   <= 1'b0;
				tx_id[n]    <= '0;
				tx_dlc[n]   <= '0;
				tx_data[n]  <= '0;
			end else begin
				if (w_omask) begin
					omask_q[n] <= hwdata;
				end
				if (w_nmask) begin
					nmask_q[n] <= hwdata[3:0];
				end
				if (w_fcr) begin
					fcen_q[n] <= hwdata[`CMH_FCR_EN];
					fc_q[n]   <= hwdata[31:`CMH_FCR_CNT_LSB];
				end else if (fc_inc) begin
					fc_q[n] <= fc_q[n] + 16'h0001;
				end
				if (take_ok[n]) begin
					busy_q[n]    <= 1'b1;
					tx_idx_q[n]  <= pick[n][4:0];
					tx_remote[n] <= !obj_cfg[pick[n][4:0]][`CMH_C_DIR];
					tx_xtd[n]    <= obj_cfg[pick[n][4:0]][`CMH_C_XTD];
					tx_id[n]     <= obj_id[pick[n][4:0]];
					tx_dlc[n]    <= obj_cfg[pick[n][4:0]][`CMH_C_DLC +: 4];
					tx_data[n]   <= obj_data[pick[n][4:0]];
				end else if (done_ok[n] || tx_fail[n]) begin
					busy_q[n] <= 1'b0;
				end
			end
		end
	end

	// ************************************************************
	// Message objects
	// ************************************************************
	for (genvar i = 0; i < `CMH_NUM_OBJ; i++) begin : g_obj
		logic       valid_q;
		logic       ipnd_q;
		logic       txpnd_q;
		logic       rxpnd_q;
		logic       new_data_flag_q;
		logic       cpu_update_lock_q;
		logic       transmit_request_q;
		logic       remote_pending_q;
		logic       tx_irq_enable_q;
		logic       rx_irq_enable_q;
		cmh_id_t    id_q;
		cmh_id_t    mask_q;
		logic [7:0] cfg_q;
		cmh_data_t  data_q;
		cmh_cnt_t   cfc_q;
		logic       wr_me;
		logic       wr_ctl;
		logic [1:0] serves;
		logic       rx_hit;
		logic       rx_dat;
		logic       rx_rmt;
		logic       tk;
		logic [1:0] dn_n;
		logic       dn;
		cmh_id_t    len_mask;

		assign wr_me  = obj_wr && (a_obj == 5'(i));
		assign wr_ctl = wr_me && (a_word == `CMH_W_CTRL);
		assign serves = {gw_q || cfg_q[`CMH_C_NODE], gw_q || !cfg_q[`CMH_C_NODE]};
		assign len_mask = cfg_q[`CMH_C_XTD] ? `CMH_EXT_ID_MASK : `CMH_STD_ID_MASK;
		assign cand[i] = valid_q && serves[r_node]
				 && (cfg_q[`CMH_C_XTD] == r_xtd)
				 && (cfg_q[`CMH_C_DIR] == r_remote)
				 && (((r_id ^ id_q) & mask_q & len_mask) == '0);
		assign rx_hit = rx_go && hit[5] && (hit[4:0] == 5'(i));
		assign rx_dat = rx_hit && !r_remote;
		assign rx_rmt = rx_hit && r_remote;
		for (genvar n = 0; n < `CMH_NUM_NODE; n++) begin : g_pend
			assign pend[n][i] = valid_q && transmit_request_q && !cpu_update_lock_q && serves[n]
					    && !(busy_q[1-n] && tx_idx_q[1-n] == 5'(i));
			assign dn_n[n] = done_v[n] && (tx_idx_q[n] == 5'(i));
			assign irq_obj[n][i] = ipnd_q && (cfg_q[`CMH_C_NODE] == n);
		end
		assign tk = (take_ok[0] && pick[0][4:0] == 5'(i)) ||
			    (take_ok[1] && pick[1][4:0] == 5'(i));
		assign dn = |dn_n;

		assign valid_w[i]   = valid_q;
		assign obj_id[i]    = id_q;
		assign obj_mask[i]  = mask_q;
		assign obj_cfg[i]   = cfg_q;
		assign obj_data[i]  = data_q;
		assign obj_cfc[i]   = cfc_q;
		assign ctrl_word[i] = {12'h000, enc(rxpnd_q), enc(txpnd_q), enc(remote_pending_q),
				       enc(transmit_request_q), enc(cpu_update_lock_q), enc(new_data_flag_q), enc(valid_q),
				       enc(tx_irq_enable_q), enc(rx_irq_enable_q), enc(ipnd_q)};

		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				valid_q  <= 1'b0;
				ipnd_q   <= 1'b0;
				txpnd_q  <= 1'b0;
				rxpnd_q  <= 1'b0;
				new_data_flag_q <= 1'b0;
				cpu_update_lock_q <= 1'b0;
				transmit_request_q   <= 1'b0;
				remote_pending_q <= 1'b0;
				tx_irq_enable_q   <= 1'b0;
				rx_irq_enable_q   <= 1'b0;
			end else begin
				valid_q  <= flag_next(valid_q, wr_ctl, hwdata[`CMH_F_VALID +: 2],
						      1'b0, 1'b0);
				cpu_update_lock_q <= flag_next(cpu_update_lock_q, wr_ctl, hwdata[`CMH_F_CPU_UPDATE_LOCK +: 2],
						      1'b0, 1'b0);
				tx_irq_enable_q   <= flag_next(tx_irq_enable_q, wr_ctl, hwdata[`CMH_F_TX_IRQ_ENABLE +: 2], 1'b0, 1'b0);
				rx_irq_enable_q   <= flag_next(rx_irq_enable_q, wr_ctl, hwdata[`CMH_F_RX_IRQ_ENABLE +: 2], 1'b0, 1'b0);
				ipnd_q   <= flag_next(ipnd_q, wr_ctl, hwdata[`CMH_F_IPND +: 2],
						      (rx_dat && rx_irq_enable_q) || (dn && tx_irq_enable_q), 1'b0);
				rxpnd_q  <= flag_next(rxpnd_q, wr_ctl, hwdata[`CMH_F_RXPND +: 2],
						      rx_dat && rx_irq_enable_q, 1'b0);
				txpnd_q  <= flag_next(txpnd_q, wr_ctl, hwdata[`CMH_F_TXPND +: 2],
						      dn && tx_irq_enable_q, 1'b0);
				new_data_flag_q <= flag_next(new_data_flag_q, wr_ctl, hwdata[`CMH_F_NEW_DATA_FLAG +: 2],
						      rx_dat, tk);
				transmit_request_q   <= flag_next(transmit_request_q, wr_ctl, hwdata[`CMH_F_TRANSMIT_REQUEST +: 2],
						      rx_rmt, dn);
				remote_pending_q <= flag_next(remote_pending_q, wr_ctl, hwdata[`CMH_F_REMOTE_PENDING +: 2],
						      rx_rmt, dn);
			end
		end

		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				id_q   <= '0;
				mask_q <= `CMH_MASK_RST;
				cfg_q  <= 8'h00;
				data_q <= '0;
				cfc_q  <= 16'h0000;
			end else begin
				if (wr_me && a_word == `CMH_W_ID) begin
					id_q <= hwdata[28:0];
				end
				if (wr_me && a_word == `CMH_W_MASK) begin
					mask_q <= hwdata[28:0];
				end
				if (wr_me && a_word == `CMH_W_CFG) begin
					cfg_q <= hwdata[7:0];
				end
				if (wr_me && a_word == `CMH_W_DLO) begin
					data_q[31:0] <= hwdata;
				end
				if (wr_me && a_word == `CMH_W_DHI) begin
					data_q[63:32] <= hwdata;
				end
				if (rx_rmt && cfg_q[`CMH_C_RMM]) begin
					id_q <= r_id;
					cfg_q[`CMH_C_DLC +: 4] <= r_dlc;
				end
				if (rx_dat) begin
					data_q <= r_data;
					cfg_q[`CMH_C_DLC +: 4] <= r_dlc;
					cfc_q  <= fc_q[r_node];
				end
				if (dn) begin
					cfc_q <= dn_n[1] ? fc_q[1] : fc_q[0];
				end
			end
		end
	end

	// ************************************************************
	// Read multiplexer
	// ************************************************************
	always_comb begin
		rd_word = 32'h0000_0000;
		if (!addr_q[`CMH_GLB_BIT]) begin
			case (a_word)
				`CMH_W_CTRL: rd_word = ctrl_word[a_obj];
				`CMH_W_ID:   rd_word = {3'h0, obj_id[a_obj]};
				`CMH_W_MASK: rd_word = {3'h0, obj_mask[a_obj]};
				`CMH_W_CFG:  rd_word = {24'h000000, obj_cfg[a_obj]};
				`CMH_W_DLO:  rd_word = obj_data[a_obj][31:0];
				`CMH_W_DHI:  rd_word = obj_data[a_obj][63:32];
				`CMH_W_CFC:  rd_word = {16'h0000, obj_cfc[a_obj]};
				default:     rd_word = 32'h0000_0000;
			endcase
		end else begin
			case (a_gidx)
				`CMH_G_IDENT0: rd_word = ident_w[0];
				`CMH_G_IDENT1: rd_word = ident_w[1];
				`CMH_G_OMASK0: rd_word = omask_q[0];
				`CMH_G_OMASK1: rd_word = omask_q[1];
				`CMH_G_NMASK0: rd_word = {28'h0000000, nmask_q[0]};
				`CMH_G_NMASK1: rd_word = {28'h0000000, nmask_q[1]};
				`CMH_G_FCR0:   rd_word = fcr_w[0];
				`CMH_G_FCR1:   rd_word = fcr_w[1];
				`CMH_G_GWCTRL: rd_word = {31'h00000000, gw_q};
				default:       rd_word = 32'h0000_0000;
			endcase
		end
	end

endmodule : cmh_msg_handler

// ### rtl/cmh_regs.svh
// Register map and field positions of the CAN message object handler.
// Assumes a 32-bit AHB-Lite slave window of 1 KiB plus a small global page.
`ifndef CMH_REGS_SVH
`define CMH_REGS_SVH

`define CMH_NUM_OBJ       32
`define CMH_NUM_NODE      2
`define CMH_ADDR_W        12
`define CMH_GLB_BIT       10
`define CMH_OBJ_MSB       9
`define CMH_OBJ_LSB       5
`define CMH_WORD_MSB      4
`define CMH_WORD_LSB      2
`define CMH_GIDX_MSB      5

// Words inside one 32-byte message object
`define CMH_W_CTRL        3'h0
`define CMH_W_ID          3'h1
`define CMH_W_MASK        3'h2
`define CMH_W_CFG         3'h3
`define CMH_W_DLO         3'h4
`define CMH_W_DHI         3'h5
`define CMH_W_CFC         3'h6

// Global words at byte 0x400 upward
`define CMH_G_IDENT0      4'h0
`define CMH_G_IDENT1      4'h1
`define CMH_G_OMASK0      4'h2
`define CMH_G_OMASK1      4'h3
`define CMH_G_NMASK0      4'h4
`define CMH_G_NMASK1      4'h5
`define CMH_G_FCR0        4'h6
`define CMH_G_FCR1        4'h7
`define CMH_G_GWCTRL      4'h8

// Two-bit flag fields of the object control word
`define CMH_F_IPND        0
`define CMH_F_RX_IRQ_ENABLE        2
`define CMH_F_TX_IRQ_ENABLE        4
`define CMH_F_VALID       6
`define CMH_F_NEW_DATA_FLAG      8
`define CMH_F_CPU_UPDATE_LOCK      10
`define CMH_F_TRANSMIT_REQUEST        12
`define CMH_F_REMOTE_PENDING      14
`define CMH_F_TXPND       16
`define CMH_F_RXPND       18
`define CMH_FLAG_SET      2'h2
`define CMH_FLAG_CLR      2'h1

// Object config word
`define CMH_C_DLC         0
`define CMH_C_DIR         4
`define CMH_C_XTD         5
`define CMH_C_NODE        6
`define CMH_C_RMM         7

`define CMH_STD_ID_MASK   29'h00007FF
`define CMH_EXT_ID_MASK   29'h1FFFFFFF
`define CMH_MASK_RST      29'h1FFFFFFF
`define CMH_IRQ_NONE      6'h00
`define CMH_IRQ_MSG_BASE  6'h01
`define CMH_IRQ_NODE_BASE 6'h21
`define CMH_FCR_EN        0
`define CMH_FCR_CNT_LSB   16
`define CMH_GW_EN         0

`endif

// ### rtl/cmh_pkg.sv
// Types shared by the CAN message object handler.
// Assumes the constants of cmh_regs.svh for all numeric layout.
package cmh_pkg;
	typedef enum logic [2:0] {
		CMH_BUS_IDLE   = 3'b001,
		CMH_BUS_RDWAIT = 3'b010,
		CMH_BUS_RDOUT  = 3'b100
	} cmh_bus_e;
	typedef logic [28:0] cmh_id_t;
	typedef logic [63:0] cmh_data_t;
	typedef logic [3:0]  cmh_dlc_t;
	typedef logic [15:0] cmh_cnt_t;
	typedef logic [5:0]  cmh_irqid_t;
endpackage : cmh_pkg

// ### test/cmh_msg_handler_properties.sv
// Port checks for the message object handler.
// Assumes a bind onto cmh_msg_handler from the bench top file.
`timescale 1ns/1ps
module cmh_props (
	input logic                   hclk,
	input logic                   hresetn,
	input logic                   hsel,
	input logic [1:0]             htrans,
	input logic                   hwrite,
	input logic                   hready,
	input logic                   hreadyout,
	input logic                   hresp,
	input logic [31:0]            hrdata,
	input logic [1:0]             rx_valid,
	input logic [1:0]             rx_ready,
	input logic [1:0]             tx_avail,
	input logic [1:0]             tx_take,
	input cmh_pkg::cmh_id_t [1:0] tx_id
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// ******
	// Bus side
	// ******
	sequence s_rd_req;
		hsel && hready && htrans[1] && !hwrite;
	endsequence
	sequence s_rd_ans;
		!hreadyout ##1 hreadyout;
	endsequence
	property p_rd_wait;
		s_rd_req |=> s_rd_ans;
	endproperty
	a_rd_wait: assert property (p_rd_wait)
		else $error("read answer not one wait cycle");
	property p_wait_one;
		!hreadyout |=> hreadyout;
	endproperty
	a_wait_one: assert property (p_wait_one)
		else $error("wait state longer than one cycle");
	property p_rdata_hold;
		$past(hreadyout) |-> $stable(hrdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read data changed outside a read");
	property p_hresp_okay;
		hresp == 1'b0;
	endproperty
	a_hresp_okay: assert property (p_hresp_okay)
		else $error("response not okay");
	// ******
	// Node side
	// ******
	property p_rx_ready;
		rx_ready[0] && (rx_ready[1] == !rx_valid[0]);
	endproperty
	a_rx_ready: assert property (p_rx_ready)
		else $error("receive ready priority wrong");
	property p_take_busy0;
		tx_take[0] && tx_avail[0] |=> !tx_avail[0];
	endproperty
	a_take_busy0: assert property (p_take_busy0)
		else $error("node 0 offers while busy");
	property p_take_busy1;
		tx_take[1] && tx_avail[1] |=> !tx_avail[1];
	endproperty
	a_take_busy1: assert property (p_take_busy1)
		else $error("node 1 offers while busy");
	property p_tx_hold;
		!(tx_take[0] && tx_avail[0]) |=> $stable(tx_id[0]);
	endproperty
	a_tx_hold: assert property (p_tx_hold)
		else $error("transmit id changed without take");
endmodule : cmh_props

// ### test/cmh_bsp_model.sv
// Behavioural bitstream processor of one node: takes and sends frames.
// Assumes the handler's take/done handshake on hclk.
`timescale 1ns/1ps
module cmh_bsp_model #(
	parameter int DONE_DLY = 6
) (
	input logic              hclk,
	input logic              hresetn,
	input logic              go,
	input logic              tx_avail,
	input cmh_pkg::cmh_id_t  tx_id,
	output logic             bus_idle,
	output logic             tx_take,
	output logic             tx_done,
	output cmh_pkg::cmh_id_t sent_id,
	output logic [7:0]       sent_cnt
);
	import cmh_pkg::*;
	logic [3:0] cnt_q;
	logic       busy_q;
	wire        start = !busy_q && tx_avail && bus_idle;
	// Bus stays idle through the take cycle, busy for the frame
	assign bus_idle = go && (!busy_q || tx_take);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy_q <= 1'b0;
			cnt_q <= 4'h0;
			tx_take <= 1'b0;
			tx_done <= 1'b0;
			sent_id <= '0;
			sent_cnt <= 8'h00;
		end else begin
			tx_take <= start;
			tx_done <= busy_q && cnt_q == DONE_DLY[3:0];
			if (start) begin
				busy_q <= 1'b1;
				cnt_q <= 4'h0;
			end else if (busy_q && cnt_q == DONE_DLY[3:0]) begin
				busy_q <= 1'b0;
				sent_id <= tx_id;
				sent_cnt <= sent_cnt + 8'h01;
			end else begin
				cnt_q <= cnt_q + 4'h1;
			end
		end
	end
endmodule : cmh_bsp_model

// ### test/testbench.sv
// Directed bench for the message object handler.
// Assumes the checker and node model files compile first.
`timescale 1ns/1ps
module testbench;
	import cmh_pkg::*;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, go = 0;
	logic [1:0] htrans = '0, rx_valid = '0, rx_remote = '0, rx_xtd = '0, tx_fail = '0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = '0, hwdata = '0, hrdata;
	logic hready, hreadyout, hresp;
	wire [1:0] rx_ready, node_bus_idle, tx_avail, tx_take, tx_done, tx_remote, tx_xtd;
	cmh_id_t [1:0] rx_id = '0, tx_id;
	cmh_dlc_t [1:0] rx_dlc = '0, tx_dlc;
	cmh_data_t [1:0] rx_data = '0, tx_data;
	logic [1:0][3:0] node_irq_src = '0;
	wire cmh_id_t sent_id [2];
	wire [7:0] sent_cnt [2];
	int err_total = 0, checks_done = 0, cyc = 0;
	assign hready = hreadyout;
	always #12.5 hclk = ~hclk;
	cmh_msg_handler u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .rx_remote(rx_remote), .rx_xtd(rx_xtd), .rx_id(rx_id),
		.rx_dlc(rx_dlc), .rx_data(rx_data), .node_bus_idle(node_bus_idle),
		.tx_avail(tx_avail), .tx_take(tx_take), .tx_done(tx_done), .tx_fail(tx_fail),
		.tx_remote(tx_remote), .tx_xtd(tx_xtd), .tx_id(tx_id), .tx_dlc(tx_dlc),
		.tx_data(tx_data), .node_irq_src(node_irq_src));
	for (genvar n = 0; n < 2; n++) begin : g_bsp
		cmh_bsp_model u_bsp (.hclk(hclk), .hresetn(hresetn), .go(go),
			.tx_avail(tx_avail[n]), .tx_id(tx_id[n]), .bus_idle(node_bus_idle[n]),
			.tx_take(tx_take[n]), .tx_done(tx_done[n]), .sent_id(sent_id[n]),
			.sent_cnt(sent_cnt[n]));
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic ahb(input logic wr, input logic [31:0] a, d, output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= a;
		do @(posedge hclk); while (!hready);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (!hready);
		q = hrdata;
	endtask : ahb
	task automatic wr(input logic [31:0] a, d);
		logic [31:0] q;
		ahb(1'b1, a, d, q);
	endtask : wr
	task automatic rd_chk(input logic [31:0] a, e, m = 32'hFFFFFFFF);
		logic [31:0] q;
		ahb(1'b0, a, 32'h0, q);
		chk(q & m, e);
	endtask : rd_chk
	task automatic frame(input int n, input logic rmt, input cmh_id_t id, input cmh_data_t d);
		rx_valid[n] <= 1'b1;
		rx_remote[n] <= rmt;
		rx_id[n] <= id;
		rx_dlc[n] <= 4'h8;
		rx_data[n] <= d;
		do @(posedge hclk); while (!rx_ready[n]);
		rx_valid[n] <= 1'b0;
		rx_id[n] <= ~id;
		rx_data[n] <= ~d;
		@(posedge hclk);
	endtask : frame
	// ******
	// Scenarios
	// ******
	task automatic t_rx;
		wr(32'h04C, 32'h08);
		wr(32'h044, 32'h123);
		wr(32'h06C, 32'h08);
		wr(32'h064, 32'h120);
		wr(32'h068, 32'h7F0);
		wr(32'h060, 32'h88);
		wr(32'h0AC, 32'h08);
		wr(32'h0A4, 32'h123);
		wr(32'h0A0, 32'h88);
		wr(32'h408, 32'hFFFFFFFF);
		rd_chk(32'h400, 32'h0);
		frame(1, 1'b0, 29'h123, 64'h1122334455667788);
		rd_chk(32'h070, 32'h0);
		frame(0, 1'b0, 29'h123, 64'h1122334455667788);
		rd_chk(32'h070, 32'h55667788);
		rd_chk(32'h074, 32'h11223344);
		rd_chk(32'h0A0, 32'h100, 32'h300);
		rd_chk(32'h050, 32'h0);
		rd_chk(32'h060, 32'h9569A, 32'hFFFFF);
		rd_chk(32'h400, 32'h4);
		wr(32'h408, 32'hFFFFFFF7);
		rd_chk(32'h400, 32'h0);
		wr(32'h060, 32'h1);
		wr(32'h408, 32'hFFFFFFFF);
		rd_chk(32'h400, 32'h0);
		$display("t_rx done");
	endtask : t_rx
	task automatic t_tx;
		wr(32'h12C, 32'h18);
		wr(32'h124, 32'h3CC);
		wr(32'h120, 32'h2880);
		wr(32'h0EC, 32'h18);
		wr(32'h0E4, 32'h2AB);
		wr(32'h0F0, 32'hCAFEF00D);
		wr(32'h0E0, 32'hAA0);
		go <= 1'b1;
		frame(0, 1'b1, 29'h2AB, 64'h0);
		frame(0, 1'b0, 29'h2AB, 64'h0);
		chk({30'h0, tx_avail}, 32'h0);
		rd_chk(32'h0F0, 32'hCAFEF00D);
		rd_chk(32'h0E0, 32'h5AAA5, 32'hFFFFF);
		wr(32'h418, 32'h1);
		go <= 1'b0;
		wr(32'h120, 32'h400);
		wr(32'h0E0, 32'h400);
		go <= 1'b1;
		while (sent_cnt[0] != 8'h01) @(posedge hclk);
		chk({3'h0, sent_id[0]}, 32'h2AB);
		chk(tx_data[0][31:0], 32'hCAFEF00D);
		chk({24'h0, tx_remote, tx_xtd, tx_dlc[0]}, 32'h08);
		while (sent_cnt[0] != 8'h02) @(posedge hclk);
		chk({3'h0, sent_id[0]}, 32'h3CC);
		repeat (2) @(posedge hclk);
		rd_chk(32'h0E0, 32'h655A6, 32'hFFFFF);
		rd_chk(32'h138, 32'h1);
		rd_chk(32'h418, 32'h00020001);
		rd_chk(32'h400, 32'h8);
		wr(32'h414, 32'h4);
		node_irq_src[1] <= 4'h6;
		rd_chk(32'h404, 32'h23);
		wr(32'h420, 32'h1);
		frame(1, 1'b0, 29'h123, 64'hA5);
		rd_chk(32'h070, 32'hA5);
		$display("t_tx done");
	endtask : t_tx
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			wrap_up();
		end
	end
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_rx();
		t_tx();
		wrap_up();
	end
endmodule : testbench
bind cmh_msg_handler cmh_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .rx_valid(rx_valid), .rx_ready(rx_ready),
	.tx_avail(tx_avail), .tx_take(tx_take), .tx_id(tx_id));
